// ==== bench/bcpr_regs_props.sv ====
// Port assertions for the colour and pattern register bank
`timescale 1ns/10ps
`default_nettype none
module bcpr_regs_props #(
	parameter int unsigned PIX = 8
) (
	// Clock, reset, bus
	input wire logic              MCLK_IN,
	input wire logic              ARST_N_IN,
	input wire logic              CLK_EN_IN,
	input wire logic              HSEL_IN,
	input wire logic [31:0]       HADDR_IN,
	input wire logic [1:0]        HTRANS_IN,
	input wire logic              HWRITE_IN,
	input wire logic [2:0]        HSIZE_IN,
	input wire logic [31:0]       HWDATA_IN,
	input wire logic              HREADY_IN,
	input wire logic              HRESP_OUT,
	// Stored values and expansion
	input wire logic [15:0]       SOURCE_COLOR_ZERO_OUT,
	input wire logic [15:0]       SOURCE_COLOR_ONE_OUT,
	input wire logic [63:0]       PATTERN_COLORS_OUT,
	input wire logic [127:0]      PATTERN_BITS_OUT,
	input wire logic              MODE_16BPP_OUT,
	input wire logic              EXP_VALID_IN,
	input wire logic              EXP_PATTERN_MODE_IN,
	input wire logic [2*PIX-1:0]  EXP_CODES_IN,
	input wire logic              EXP_VALID_OUT,
	input wire logic [16*PIX-1:0] EXP_PIXELS_OUT
);
	logic        go;
	logic [15:0] pat_sel;
	assign go = EXP_VALID_IN && CLK_EN_IN && MODE_16BPP_OUT;
	assign pat_sel = PATTERN_COLORS_OUT[16*EXP_CODES_IN[3:2] +: 16];
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	sequence s_wr(a);
		HSEL_IN && HREADY_IN && CLK_EN_IN && HTRANS_IN == 2'h2 &&
		HWRITE_IN && HSIZE_IN == 3'h2 && HADDR_IN == a ##1 CLK_EN_IN;
	endsequence
	a_src0_write: assert property (s_wr(32'h20430) |=>
		SOURCE_COLOR_ZERO_OUT == $past(HWDATA_IN[15:0]))
		else $error("source colour zero not stored");
	a_bits_write: assert property (s_wr(32'h20480) |=>
		PATTERN_BITS_OUT[31:0] == $past(HWDATA_IN))
		else $error("pattern low word not stored");
	a_resp_okay: assert property (HRESP_OUT == 1'h0)
		else $error("bus response not okay");
	a_exp_pulse: assert property (EXP_VALID_IN && CLK_EN_IN |=>
		EXP_VALID_OUT) else $error("expansion valid missing");
	a_exp_quiet: assert property (!EXP_VALID_IN && CLK_EN_IN |=>
		!EXP_VALID_OUT) else $error("expansion valid unexpected");
	a_src_zero: assert property (go && !EXP_PATTERN_MODE_IN &&
		!EXP_CODES_IN[0] |=>
		EXP_PIXELS_OUT[15:0] == $past(SOURCE_COLOR_ZERO_OUT))
		else $error("clear bit pixel colour wrong");
	a_src_one: assert property (go && !EXP_PATTERN_MODE_IN &&
		EXP_CODES_IN[0] |=>
		EXP_PIXELS_OUT[15:0] == $past(SOURCE_COLOR_ONE_OUT))
		else $error("set bit pixel colour wrong");
	a_pat_pick: assert property (go && EXP_PATTERN_MODE_IN |=>
		EXP_PIXELS_OUT[31:16] == $past(pat_sel))
		else $error("pattern pixel colour wrong");
endmodule
bind bcpr_regs bcpr_regs_props #(.PIX(PIX)) u_props (.MCLK_IN,
	.ARST_N_IN, .CLK_EN_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN,
	.HWRITE_IN, .HSIZE_IN, .HWDATA_IN, .HREADY_IN, .HRESP_OUT,
	.SOURCE_COLOR_ZERO_OUT, .SOURCE_COLOR_ONE_OUT, .PATTERN_COLORS_OUT,
	.PATTERN_BITS_OUT, .MODE_16BPP_OUT, .EXP_VALID_IN,
	.EXP_PATTERN_MODE_IN, .EXP_CODES_IN, .EXP_VALID_OUT,
	.EXP_PIXELS_OUT);
`default_nettype wire

// ==== bench/blit_color_pattern_regs_tb_top.sv ====
// Self-checking bench for the colour and pattern register bank
`timescale 1ns/10ps
`default_nettype none
module blit_color_pattern_regs_tb_top;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              ce = 1'b1;
	logic              sel = 1'b0;
	logic [1:0]        tr = 2'h0;
	logic [31:0]       ad = 32'h0;
	logic              wr = 1'b0;
	logic [2:0]        sz = 3'h0;
	logic [31:0]       wd = 32'h0;
	logic              ev = 1'b0;
	logic              pm = 1'b0;
	logic [15:0]       codes = 16'h0;
	wire logic [31:0]  rd;
	wire logic         rdy;
	wire logic [15:0]  src0;
	wire logic [15:0]  src1;
	wire logic [63:0]  patc;
	wire logic [127:0] bits;
	wire logic         evo;
	wire logic [127:0] pix;
	wire logic         hresp;
	wire logic [31:0]  lvw;
	wire logic [31:0]  lvr;
	wire logic         m16;
	integer            miscompares = 0;
	integer            n_tests = 0;
	integer            cyc = 0;
	logic [31:0]       r;
	logic [127:0]      e;

	bcpr_regs u_bcpr_regs (.MCLK_IN(clk), .ARST_N_IN(rst_n),
		.CLK_EN_IN(ce), .HSEL_IN(sel), .HADDR_IN(ad), .HTRANS_IN(tr),
		.HWRITE_IN(wr), .HSIZE_IN(sz), .HWDATA_IN(wd), .HREADY_IN(rdy),
		.HRDATA_OUT(rd), .HREADYOUT_OUT(rdy), .HRESP_OUT(hresp),
		.SOURCE_COLOR_ZERO_OUT(src0), .SOURCE_COLOR_ONE_OUT(src1),
		.PATTERN_COLORS_OUT(patc), .PATTERN_BITS_OUT(bits),
		.LEGACY_VIDEO_WRITE_OUT(lvw), .LEGACY_VIDEO_READ_OUT(lvr),
		.MODE_16BPP_OUT(m16), .EXP_VALID_IN(ev), .EXP_PATTERN_MODE_IN(pm),
		.EXP_CODES_IN(codes), .EXP_VALID_OUT(evo), .EXP_PIXELS_OUT(pix));

	always #50 clk = ~clk;

	function automatic logic [31:0] val(int i);
		return {8'(i), 8'ha5, 8'(i + 16), 8'(i * 7 + 2)};
	endfunction

	// Narrow mode colour: index byte repeated in the upper byte
	function automatic logic [31:0] dup(int i);
		logic [31:0] v;
		v = val(i);
		return {16'h0, v[7:0], v[7:0]};
	endfunction

	function automatic logic [31:0] adr(int i);
		return {14'h0, bcpr_pkg::STORE_INDEX[i], 2'h0};
	endfunction

	// Narrow mode repeats the low byte of the chosen colour
	function automatic logic [127:0] epix(logic m, logic p,
			logic [15:0] c);
		logic [15:0] k;
		for (int q = 0; q < 8; q++) begin
			k = p ? 16'(val(2 + c[2*q +: 2])) : 16'(val(c[2*q]));
			if (!m)
				k = {k[7:0], k[7:0]};
			epix[16*q +: 16] = k;
		end
	endfunction

	task automatic chk(input string n, input logic [127:0] x, g);
		n_tests++;
		if (g !== x) begin
			$display("MISMATCH %s expected %h seen %h", n, x, g);
			miscompares++;
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, d);
		@(posedge clk);
		sel <= 1'b1;
		tr <= 2'h2;
		wr <= w;
		ad <= a;
		sz <= 3'h2;
		do @(posedge clk); while (rdy !== 1'b1);
		sel <= 1'b0;
		tr <= 2'h0;
		wd <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		r = rd;
	endtask

	task automatic xp(input logic p, input logic [15:0] c);
		@(posedge clk);
		ev <= 1'b1;
		pm <= p;
		codes <= c;
		@(posedge clk);
		ev <= 1'b0;
		#1;
		chk("expand valid", 128'h1, {127'h0, evo});
	endtask

	task automatic end_sim;
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Ceiling well above the roughly 160 cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			end_sim;
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			ahb(1'b0, adr(i), 32'h0);
			chk("reset read", 128'h0, r);
		end
		chk("pattern bits reset", 128'h0, bits);
		$display("test reset done");
		for (int i = 0; i < 12; i++)
			ahb(1'b1, adr(i), val(i));
		// All written before any read, so aliasing shows up
		for (int i = 0; i < 12; i++) begin
			ahb(1'b0, adr(i), 32'h0);
			e = bcpr_pkg::STORE_WIDTH[i] == 16 ? 16'(val(i)) : val(i);
			chk("readback", e, r);
		end
		chk("pattern bits", {val(9), val(8), val(7), val(6)}, bits);
		chk("source colours", {16'(val(1)), 16'(val(0))},
			{src1, src0});
		chk("legacy outputs", {val(11), val(10)}, {lvr, lvw});
		e = 128'h0;
		for (int q = 0; q < 4; q++)
			e[16*q +: 16] = 16'(val(2 + q));
		chk("pattern colours", e, patc);
		ahb(1'b0, 32'h20432, 32'h0);
		chk("misaligned read", 128'h0, r);
		ahb(1'b0, 32'h20600, 32'h0);
		chk("unmapped read", 128'h0, r);
		chk("response", 128'h0, {127'h0, hresp});
		$display("test registers done");
		for (int m = 1; m >= 0; m--) begin
			ahb(1'b1, adr(12), 32'(m));
			if (m == 0) begin
				for (int i = 0; i < 6; i++)
					ahb(1'b1, adr(i), dup(i));
			end
			for (int p = 0; p < 2; p++) begin
				xp(1'(p), 16'he4b1);
				chk("pixels", epix(1'(m), 1'(p), 16'he4b1),
					pix);
			end
			chk("pixel mode", 128'(m), {127'h0, m16});
		end
		// Four beats were expanded; a write clears the count
		ahb(1'b0, {14'h0, bcpr_pkg::IDX_EXPAND_STATUS, 2'h0}, 32'h0);
		chk("beat count", 128'h4, r);
		ahb(1'b1, {14'h0, bcpr_pkg::IDX_EXPAND_STATUS, 2'h0}, 32'h0);
		ahb(1'b0, {14'h0, bcpr_pkg::IDX_EXPAND_STATUS, 2'h0}, 32'h0);
		chk("beat clear", 128'h0, r);
		$display("test expansion done");
		end_sim;
	end
endmodule
`default_nettype wire

// ==== rtl/bcpr_expand.sv ====
// Per-pixel colour expansion of source and pattern codes
`timescale 1ns/10ps
`default_nettype none

module bcpr_expand #(
	parameter int unsigned PIX = 8,
	parameter int unsigned CW  = 16
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              arst_n_in,
	input  wire logic              ce_in,
	// Request
	input  wire logic              valid_in,
	input  wire logic              pattern_mode_in,
	input  wire logic              mode_16bpp_in,
	input  wire logic [2*PIX-1:0]  codes_in,
	// Colours
	input  wire logic [CW-1:0]     src0_in,
	input  wire logic [CW-1:0]     src1_in,
	input  wire logic [4*CW-1:0]   pat_in,
	// Result
	output logic                   valid_out,
	output logic      [CW*PIX-1:0] pixels_out
);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			valid_out <= 1'b0;
		end else if (ce_in) begin
			valid_out <= valid_in;
		end
	end

	for (genvar p = 0; p < PIX; p++) begin : g_pix
		logic [1:0]    code;
		logic [CW-1:0] color;
		logic [CW-1:0] shown;
		assign code = codes_in[2*p +: 2];
		always_comb begin
			if (pattern_mode_in) begin
				color = pat_in[CW*code +: CW];
			end else if (code[0]) begin
				color = src1_in;
			end else begin
				color = src0_in;
			end
			// Full word is one RGB pixel; else the index byte is doubled
			if (mode_16bpp_in) begin
				shown = color;
			end else begin
				shown = {color[7:0], color[7:0]};
			end
		end
		always_ff @(posedge clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				pixels_out[CW*p +: CW] <= '0;
			end else if (ce_in && valid_in) begin
				pixels_out[CW*p +: CW] <= shown;
			end
		end
	end

endmodule

`default_nettype wire

// ==== rtl/bcpr_pkg.sv ====
// Shared constants for the colour and pattern register bank
package bcpr_pkg;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_SOURCE_COLOR_ZERO   = 16'h810c;
	localparam logic [15:0] IDX_SOURCE_COLOR_ONE    = 16'h810e;
	localparam logic [15:0] IDX_PATTERN_COLOR_ZERO  = 16'h8110;
	localparam logic [15:0] IDX_PATTERN_COLOR_ONE   = 16'h8112;
	localparam logic [15:0] IDX_PATTERN_COLOR_TWO   = 16'h8114;
	localparam logic [15:0] IDX_PATTERN_COLOR_THREE = 16'h8116;
	localparam logic [15:0] IDX_PATTERN_BITS_LOW    = 16'h8120;
	localparam logic [15:0] IDX_PATTERN_BITS_SECOND = 16'h8124;
	localparam logic [15:0] IDX_PATTERN_BITS_THIRD  = 16'h8128;
	localparam logic [15:0] IDX_PATTERN_BITS_HIGH   = 16'h812c;
	localparam logic [15:0] IDX_LEGACY_VIDEO_WRITE  = 16'h8140;
	localparam logic [15:0] IDX_LEGACY_VIDEO_READ   = 16'h8144;
	localparam logic [15:0] IDX_PIXEL_MODE          = 16'h8150;
	localparam logic [15:0] IDX_EXPAND_STATUS       = 16'h8154;

	// Storage slots, in the order of the arrays below
	localparam int unsigned NSTORE      = 13;
	localparam int unsigned SLOT_SRC0   = 0;
	localparam int unsigned SLOT_SRC1   = 1;
	localparam int unsigned SLOT_PAT0   = 2;
	localparam int unsigned SLOT_PAT1   = 3;
	localparam int unsigned SLOT_PAT2   = 4;
	localparam int unsigned SLOT_PAT3   = 5;
	localparam int unsigned SLOT_BITS0  = 6;
	localparam int unsigned SLOT_BITS1  = 7;
	localparam int unsigned SLOT_BITS2  = 8;
	localparam int unsigned SLOT_BITS3  = 9;
	localparam int unsigned SLOT_VGA_WR = 10;
	localparam int unsigned SLOT_VGA_RD = 11;
	localparam int unsigned SLOT_MODE   = 12;

	localparam logic [15:0] STORE_INDEX [NSTORE] = '{
		IDX_SOURCE_COLOR_ZERO, IDX_SOURCE_COLOR_ONE,
		IDX_PATTERN_COLOR_ZERO, IDX_PATTERN_COLOR_ONE,
		IDX_PATTERN_COLOR_TWO, IDX_PATTERN_COLOR_THREE,
		IDX_PATTERN_BITS_LOW, IDX_PATTERN_BITS_SECOND,
		IDX_PATTERN_BITS_THIRD, IDX_PATTERN_BITS_HIGH,
		IDX_LEGACY_VIDEO_WRITE, IDX_LEGACY_VIDEO_READ,
		IDX_PIXEL_MODE
	};
	localparam int unsigned STORE_WIDTH [NSTORE] = '{
		16, 16, 16, 16, 16, 16, 32, 32, 32, 32, 32, 32, 1
	};
	// Write-side legacy register has no defined reset; zero is chosen
	localparam logic [31:0] STORE_RESET [NSTORE] = '{
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000
	};

	// Pixel mode register field
	localparam int unsigned MODE_16BPP_BIT = 0;
	localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;

	// Bus encodings
	localparam int unsigned ADDR_W      = 18;
	localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
	localparam logic [2:0]  HSIZE_WORD  = 3'h2;

	localparam int unsigned COLOR_W  = 16;
	localparam int unsigned PIXELS   = 8;
	localparam int unsigned PATTERN_W = 128;

endpackage

// ==== rtl/bcpr_reg_word.sv ====
// One software-writable storage word with reset value
`timescale 1ns/10ps
`default_nettype none

module bcpr_reg_word #(
	parameter int unsigned WIDTH = 32,
	parameter logic [31:0] RESET = 32'h0000_0000
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             arst_n_in,
	input  wire logic             ce_in,
	// Write port
	input  wire logic             we_in,
	input  wire logic [WIDTH-1:0] wdata_in,
	// Stored value
	output logic      [WIDTH-1:0] q_out
);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q_out <= RESET[WIDTH-1:0];
		end else if (ce_in && we_in) begin
			q_out <= wdata_in;
		end
	end

endmodule

`default_nettype wire

// ==== rtl/bcpr_regs.sv ====
// Colour and pattern register bank with AHB-Lite slave and expander
//
// Contract
// - Source bit 0 pixels take source colour zero.
// - Source bit 1 pixels take source colour one.
// - Pattern colours zero to three supply pattern expansion colours.
// - Four pattern words form 128 bits, word zero lowest.
// - Colour and pattern registers clear to zero on reset.
// - Read-side legacy register resets to zero; write side undefined.
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module bcpr_regs #(
	parameter int unsigned PIX = bcpr_pkg::PIXELS
) (
	// Clock, reset, enable
	input  wire logic                  MCLK_IN,
	input  wire logic                  ARST_N_IN,
	input  wire logic                  CLK_EN_IN,
	// AHB-Lite slave
	input  wire logic                  HSEL_IN,
	input  wire logic [31:0]           HADDR_IN,
	input  wire logic [1:0]            HTRANS_IN,
	input  wire logic                  HWRITE_IN,
	input  wire logic [2:0]            HSIZE_IN,
	input  wire logic [31:0]           HWDATA_IN,
	input  wire logic                  HREADY_IN,
	output logic      [31:0]           HRDATA_OUT,
	output logic                       HREADYOUT_OUT,
	output logic                       HRESP_OUT,
	// Colours and pattern to the drawing engine
	output logic      [15:0]           SOURCE_COLOR_ZERO_OUT,
	output logic      [15:0]           SOURCE_COLOR_ONE_OUT,
	output logic      [63:0]           PATTERN_COLORS_OUT,
	output logic      [127:0]          PATTERN_BITS_OUT,
	output logic      [31:0]           LEGACY_VIDEO_WRITE_OUT,
	output logic      [31:0]           LEGACY_VIDEO_READ_OUT,
	output logic                       MODE_16BPP_OUT,
	// Expansion request
	input  wire logic                  EXP_VALID_IN,
	input  wire logic                  EXP_PATTERN_MODE_IN,
	input  wire logic [2*PIX-1:0]      EXP_CODES_IN,
	// Expansion result
	output logic                       EXP_VALID_OUT,
	output logic      [16*PIX-1:0]     EXP_PIXELS_OUT
);

	localparam int unsigned NS = bcpr_pkg::NSTORE;
	localparam int unsigned AW = bcpr_pkg::ADDR_W;

	// Address phase decode
	logic           addr_take;
	logic           word_ok;
	logic [15:0]    addr_index;
	logic           hit_store;
	logic           hit_status;
	logic [3:0]     hit_slot;

	// Data phase state
	logic           wr_store_q;
	logic           wr_status_q;
	logic [3:0]     wr_slot_q;
	logic [31:0]    rdata_q;
	logic [31:0]    rdata_d;

	// Stored values, zero-extended
	logic [31:0]    store_val [NS];
	logic [NS-1:0]  store_we;

	// Expansion statistics
	logic [31:0]    beat_count_q;

	assign addr_take = HSEL_IN && HREADY_IN && CLK_EN_IN
		&& (HTRANS_IN == bcpr_pkg::HTRANS_NSEQ);
	assign word_ok = (HSIZE_IN == bcpr_pkg::HSIZE_WORD)
		&& (HADDR_IN[1:0] == 2'h0)
		&& (HADDR_IN[31:AW] == '0);
	assign addr_index = HADDR_IN[AW-1:2];

	always_comb begin
		hit_store  = 1'b0;
		hit_slot   = 4'h0;
		hit_status = word_ok
			&& (addr_index == bcpr_pkg::IDX_EXPAND_STATUS);
		for (int i = 0; i < NS; i++) begin
			if (word_ok && addr_index == bcpr_pkg::STORE_INDEX[i]) begin
				hit_store = 1'b1;
				hit_slot  = 4'(i);
			end
		end
	end

	// Write data arrives one cycle after its address
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			wr_store_q  <= 1'b0;
			wr_status_q <= 1'b0;
			wr_slot_q   <= 4'h0;
		end else if (CLK_EN_IN) begin
			wr_store_q  <= addr_take && HWRITE_IN && hit_store;
			wr_status_q <= addr_take && HWRITE_IN && hit_status;
			wr_slot_q   <= hit_slot;
		end
	end

	for (genvar i = 0; i < NS; i++) begin : g_store
		localparam int unsigned W = bcpr_pkg::STORE_WIDTH[i];
		logic [W-1:0] q;
		assign store_we[i] = wr_store_q && (wr_slot_q == 4'(i));
		bcpr_reg_word #(
			.WIDTH (W),
			.RESET (bcpr_pkg::STORE_RESET[i])
		) u_word (
			.clk_in    (MCLK_IN),
			.arst_n_in (ARST_N_IN),
			.ce_in     (CLK_EN_IN),
			.we_in     (store_we[i]),
			.wdata_in  (HWDATA_IN[W-1:0]),
			.q_out     (q)
		);
		if (W < 32) begin : g_ext
			assign store_val[i] = {{(32-W){1'b0}}, q};
		end else begin : g_full
			assign store_val[i] = q;
		end
	end

	// A read right behind a write to the same storage word sees the new data
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (hit_store) begin
			rdata_d = store_val[hit_slot];
			if (wr_store_q && wr_slot_q == hit_slot) begin
				for (int i = 0; i < NS; i++) begin
					if (hit_slot == 4'(i)) begin
						rdata_d = HWDATA_IN & ((i == int'(bcpr_pkg::SLOT_MODE))
							? 32'h0000_0001
							: ((bcpr_pkg::STORE_WIDTH[i] == 16)
								? 32'h0000_ffff : 32'hffff_ffff));
					end
				end
			end
		end else if (hit_status) begin
			rdata_d = beat_count_q;
		end
	end

	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rdata_q <= 32'h0000_0000;
		end else if (addr_take && !HWRITE_IN) begin
			rdata_q <= rdata_d;
		end
	end

	// Zero wait states; a frozen clock enable stalls the bus instead
	assign HREADYOUT_OUT = CLK_EN_IN;
	assign HRESP_OUT     = 1'b0;
	assign HRDATA_OUT    = rdata_q;

	// Counts expansion beats; a status write clears, a beat in that cycle counts
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			beat_count_q <= bcpr_pkg::STATUS_RESET;
		end else if (CLK_EN_IN) begin
			if (wr_status_q) begin
				beat_count_q <= {31'h0, EXP_VALID_IN};
			end else if (EXP_VALID_IN) begin
				beat_count_q <= beat_count_q + 32'h0000_0001;
			end
		end
	end

	assign SOURCE_COLOR_ZERO_OUT = store_val[bcpr_pkg::SLOT_SRC0][15:0];
	assign SOURCE_COLOR_ONE_OUT  = store_val[bcpr_pkg::SLOT_SRC1][15:0];
	assign PATTERN_COLORS_OUT = {
		store_val[bcpr_pkg::SLOT_PAT3][15:0],
		store_val[bcpr_pkg::SLOT_PAT2][15:0],
		store_val[bcpr_pkg::SLOT_PAT1][15:0],
		store_val[bcpr_pkg::SLOT_PAT0][15:0]
	};
	assign PATTERN_BITS_OUT = {
		store_val[bcpr_pkg::SLOT_BITS3],
		store_val[bcpr_pkg::SLOT_BITS2],
		store_val[bcpr_pkg::SLOT_BITS1],
		store_val[bcpr_pkg::SLOT_BITS0]
	};
	assign LEGACY_VIDEO_WRITE_OUT = store_val[bcpr_pkg::SLOT_VGA_WR];
	assign LEGACY_VIDEO_READ_OUT  = store_val[bcpr_pkg::SLOT_VGA_RD];
	assign MODE_16BPP_OUT =
		store_val[bcpr_pkg::SLOT_MODE][bcpr_pkg::MODE_16BPP_BIT];

	bcpr_expand #(
		.PIX (PIX),
		.CW  (bcpr_pkg::COLOR_W)
	) u_expand (
		.clk_in          (MCLK_IN),
		.arst_n_in       (ARST_N_IN),
		.ce_in           (CLK_EN_IN),
		.valid_in        (EXP_VALID_IN),
		.pattern_mode_in (EXP_PATTERN_MODE_IN),
		.mode_16bpp_in   (MODE_16BPP_OUT),
		.codes_in        (EXP_CODES_IN),
		.src0_in         (SOURCE_COLOR_ZERO_OUT),
		.src1_in         (SOURCE_COLOR_ONE_OUT),
		.pat_in          (PATTERN_COLORS_OUT),
		.valid_out       (EXP_VALID_OUT),
		.pixels_out      (EXP_PIXELS_OUT)
	);

endmodule

`default_nettype wire
